/* rtl/lift_speed_ref_select.sv */
// Decided for this implementation: the register offsets and register access over APB.
module lift_speed_ref_select #(
  parameter int TUNE_TIMEOUT = lift_ref_pkg::TUNE_WAIT_CYC
) (
  input  wire logic        pclk,           // system clock
  input  wire logic        presetn,        // async reset, low
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [7:0]  paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata_r,       // apb read data
  output logic             pready_r,       // apb ready
  output logic             pslverr_r,      // apb error
  input  wire lift_ref_pkg::pins_s pins,   // select and run pins
  input  wire logic        stop_cmd_in,    // normal stop command
  input  wire logic        brake_req_in,   // brake open request
  input  wire logic        release_in,     // brake open, delays done
  input  wire logic        tuning_done_in, // tuning finished pulse
  input  wire logic        tuning_ok_in,   // all steps succeeded
  input  wire logic        tuning_fault_in,// fault seen in tuning
  input  wire logic [15:0] ref_volt_in,    // voltage input ref
  input  wire logic [15:0] ref_curr_in,    // current input ref
  input  wire logic [15:0] ref_fbus_in,    // fieldbus ref
  input  wire logic [15:0] ref_keypad_in,  // keypad ref
  output logic      [15:0] speed_ref_r,    // frequency reference
  output logic      [2:0]  preset_idx_r,   // decoded preset
  output logic             run_enable_r,   // normal run allowed
  output logic             stop_state_r,   // stop state active
  output logic             ref_hold_r,     // reference frozen
  output logic             round_en_r,     // jerk rounding on
  output logic             tail_jerk_r,    // hold-end jerks on
  output logic             brake_ctrl_r,   // brake open drive
  output logic             tuning_run_r,   // tuning in progress
  output logic             tuning_warn_r   // tuning warning
);
  import lift_ref_pkg::*;

  function automatic logic [2:0] decode_idx(
    input logic [2:0] mode, input logic a, input logic b,
    input logic c, input logic rev);
    logic [1:0] act;
    act = c ? 2'h3 : b ? 2'h2 : a ? 2'h1 : 2'h0;
    case (mode)
      REF_ACTDIR: decode_idx = {rev, act};
      REF_BIN:    decode_idx = {c, b, a};
      default:    decode_idx = {1'b0, act};
    endcase
  endfunction

  function automatic logic [15:0] to_freq(
    input logic [15:0] lin, input logic [15:0] nf,
    input logic [15:0] nl);
    logic [31:0] q;
    q = 32'h0;
    if (nl != 16'h0)
      q = (32'(lin) * 32'(nf)) / 32'(nl);
    to_freq = (q[31:16] != 16'h0) ? 16'hFFFF : q[15:0];
  endfunction

  // estimate only: v^2 span over twice the distance less jerk travel
  function automatic logic [15:0] calc_decel(
    input logic [15:0] vn, input logic [15:0] vl,
    input logic [15:0] j, input logic [15:0] d);
    logic [31:0] num;
    logic [31:0] den;
    logic [31:0] corr;
    logic [31:0] q;
    num = 32'h0;
    if (vn > vl)
      num = 32'(vn) * 32'(vn) - 32'(vl) * 32'(vl);
    den = {15'h0, d, 1'b0};
    corr = (32'(vn) + 32'(vl)) * 32'(j) >> 8;
    if (corr < den)
      den = den - corr;
    q = num / den;
    calc_decel = (q[31:16] != 16'h0) ? 16'hFFFF : q[15:0];
  endfunction

  pins_s       s1_r, s2_r, s3_r, pin_r;
  pins_s       agree;
  logic [4:0]  ctrl_r;
  logic [15:0] hold_r, nom_lin_r, nom_frq_r, dist1_r, dist2_r;
  logic [15:0] jdi_r, decel1_r, ramp_sw_r, hold_cnt_r;
  logic [15:0] lin_r [8];
  logic [15:0] frq_r [8];
  logic [2:0]  rc_idx_r, tune_sel_r, idx_now;
  logic        rc_busy_r, rc_start;
  logic [31:0] rd_mux, tmo_r;
  logic        hit, wr_en, start, start_d_r, start_rise;
  logic        rel_d_r, hold_done_r, fault_seen_r, stop_set;
  logic        tune_fail, tune_wr, stop_lat_r;
  logic [15:0] ref_mux;
  tune_st_e    ts_r;

  // pin synchroniser: value moves once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      pin_r <= '0;
    end else begin
      s1_r  <= pins;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      pin_r <= (s2_r & agree) | (pin_r & ~agree);
    end
  end
  assign agree = ~(s2_r ^ s3_r);

  assign start      = pin_r.fwd | pin_r.rev;
  assign start_rise = start & ~start_d_r;
  assign wr_en      = psel & penable & pready_r & pwrite;
  assign tune_wr    = wr_en && (paddr == OFS_TUNE);

  // one wait state so read data leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else if (psel && penable && !pready_r) begin
      pready_r  <= 1'b1;
      pslverr_r <= ~hit;
      prdata_r  <= pwrite ? 32'h0 : rd_mux;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0;
    if (paddr[1:0] != 2'h0)
      hit = 1'b0;
    else if (paddr[7:5] == PAGE_LIN)
      rd_mux = {16'h0, lin_r[paddr[4:2]]};
    else if (paddr[7:5] == PAGE_FRQ)
      rd_mux = {16'h0, frq_r[paddr[4:2]]};
    else
      case (paddr)
        OFS_CTRL:   rd_mux = {27'h0, ctrl_r};
        OFS_TUNE:   rd_mux = {29'h0, tune_sel_r};
        OFS_HOLD:   rd_mux = {16'h0, hold_r};
        OFS_NOMLIN: rd_mux = {16'h0, nom_lin_r};
        OFS_NOMFRQ: rd_mux = {16'h0, nom_frq_r};
        OFS_DIST1:  rd_mux = {16'h0, dist1_r};
        OFS_DIST2:  rd_mux = {16'h0, dist2_r};
        OFS_DECEL1: rd_mux = {16'h0, decel1_r};
        OFS_RAMPSW: rd_mux = {16'h0, ramp_sw_r};
        OFS_JERKDI: rd_mux = {16'h0, jdi_r};
        OFS_STAT:   rd_mux = {23'h0, preset_idx_r, rc_busy_r,
                              ref_hold_r, stop_state_r,
                              run_enable_r, tuning_run_r,
                              tuning_warn_r};
        default:    hit = 1'b0;
      endcase
  end

  assign rc_start = wr_en && ((paddr == OFS_NOMLIN &&
                     pwdata[15:0] != nom_lin_r) ||
                     paddr == OFS_NOMFRQ ||
                     paddr[7:5] == PAGE_LIN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= RST_CTRL;
      hold_r    <= RST_HOLD;
      nom_lin_r <= RST_NOMLIN;
      nom_frq_r <= RST_NOMFRQ;
      dist1_r   <= 16'h0000;
      dist2_r   <= 16'h0000;
      jdi_r     <= 16'h0000;
      for (int i = 0; i < 8; i++)
        lin_r[i] <= RST_PRESET;
    end else if (wr_en) begin
      if (paddr[7:5] == PAGE_LIN && paddr[1:0] == 2'h0)
        lin_r[paddr[4:2]] <= pwdata[15:0];
      case (paddr)
        OFS_CTRL:   ctrl_r    <= pwdata[4:0];
        OFS_HOLD:   hold_r    <= pwdata[15:0];
        OFS_NOMLIN: nom_lin_r <= pwdata[15:0];
        OFS_NOMFRQ: nom_frq_r <= pwdata[15:0];
        OFS_DIST1:  dist1_r   <= pwdata[15:0];
        OFS_DIST2:  dist2_r   <= pwdata[15:0];
        OFS_JERKDI: jdi_r     <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // serial rescale, one preset per cycle; a new trigger restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_busy_r <= 1'b0;
      rc_idx_r  <= 3'h0;
      for (int i = 0; i < 8; i++)
        frq_r[i] <= RST_PRESET;
    end else if (rc_start) begin
      rc_busy_r <= 1'b1;
      rc_idx_r  <= 3'h0;
    end else if (rc_busy_r) begin
      frq_r[rc_idx_r] <= to_freq(lin_r[rc_idx_r], nom_frq_r,
                                 nom_lin_r);
      rc_idx_r  <= rc_idx_r + 3'h1;
      rc_busy_r <= (rc_idx_r != 3'h7);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      decel1_r <= 16'h0000;
    else if (wr_en && paddr == OFS_DIST1 &&
             pwdata[15:0] != 16'h0 && pwdata[15:0] != dist1_r)
      decel1_r <= calc_decel(nom_lin_r, lin_r[0], jdi_r,
                             pwdata[15:0]);
    else if (wr_en && paddr == OFS_DECEL1)
      decel1_r <= pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ramp_sw_r <= 16'h0000;
    else if (dist2_r != 16'h0)
      ramp_sw_r <= frq_r[0];
    else if (wr_en && paddr == OFS_RAMPSW)
      ramp_sw_r <= pwdata[15:0];
  end

  assign tune_fail = (ts_r == TS_RUN) && !stop_cmd_in &&
                     tuning_done_in &&
                     (fault_seen_r | tuning_fault_in | ~tuning_ok_in);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_r         <= TS_IDLE;
      tune_sel_r   <= TUNE_NONE;
      tmo_r        <= 32'h0;
      fault_seen_r <= 1'b0;
    end else begin
      case (ts_r)
        TS_IDLE:
          if (tune_wr && pwdata[2:0] <= TUNE_ENC &&
              pwdata[31:3] == 29'h0) begin
            tune_sel_r <= pwdata[2:0];
            if (pwdata[2:0] != TUNE_NONE) begin
              ts_r  <= TS_ARMED;
              tmo_r <= 32'(TUNE_TIMEOUT);
            end
          end
        TS_ARMED:
          if (stop_cmd_in ||
              (tune_wr && pwdata[2:0] == TUNE_NONE)) begin
            ts_r       <= TS_IDLE;
            tune_sel_r <= TUNE_NONE;
          end else if (start_rise) begin
            ts_r         <= TS_RUN;
            fault_seen_r <= 1'b0;
          end else if (tmo_r <= 32'h1) begin
            ts_r       <= TS_IDLE;
            tune_sel_r <= TUNE_NONE;
          end else begin
            tmo_r <= tmo_r - 32'h1;
          end
        TS_RUN:
          if (stop_cmd_in) begin
            ts_r       <= TS_IDLE;
            tune_sel_r <= TUNE_NONE;
          end else begin
            // a fault is only noted; the run goes on to its end
            if (tuning_fault_in)
              fault_seen_r <= 1'b1;
            if (tuning_done_in) begin
              ts_r       <= TS_REARM;
              tune_sel_r <= tune_fail ? TUNE_FAIL
                                      : TUNE_NONE;
            end
          end
        TS_REARM:
          if (!start)
            ts_r <= TS_IDLE;
        default:
          ts_r <= TS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tuning_warn_r <= 1'b0;
    else if (tune_fail)
      tuning_warn_r <= 1'b1;
    else if (wr_en && paddr == OFS_STAT && pwdata[STAT_WARN])
      tuning_warn_r <= 1'b0;
  end

  assign stop_set = ctrl_r[CTRL_STOPM] & start &
                    ~(pin_r.a | pin_r.b | pin_r.c);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_lat_r   <= 1'b0;
      stop_state_r <= 1'b0;
      run_enable_r <= 1'b0;
      start_d_r    <= 1'b0;
      brake_ctrl_r <= 1'b0;
      tuning_run_r <= 1'b0;
      round_en_r   <= 1'b0;
    end else begin
      start_d_r <= start;
      if (stop_set)
        stop_lat_r <= 1'b1;
      else if (!start)
        stop_lat_r <= 1'b0;
      stop_state_r <= stop_lat_r | stop_set;
      run_enable_r <= start & ~stop_lat_r & ~stop_set &
                      ~stop_cmd_in & (ts_r == TS_IDLE);
      brake_ctrl_r <= brake_req_in & (ts_r == TS_IDLE);
      tuning_run_r <= (ts_r == TS_RUN);
      round_en_r   <= ctrl_r[CTRL_JERK];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_d_r     <= 1'b0;
      ref_hold_r  <= 1'b0;
      hold_done_r <= 1'b0;
      hold_cnt_r  <= 16'h0000;
      tail_jerk_r <= 1'b0;
    end else begin
      rel_d_r     <= release_in;
      tail_jerk_r <= ctrl_r[CTRL_JERK] & hold_done_r;
      if (!run_enable_r) begin
        ref_hold_r  <= 1'b0;
        hold_done_r <= 1'b0;
      end else if (release_in && !rel_d_r && !ref_hold_r &&
                   !hold_done_r) begin
        ref_hold_r  <= (hold_r != 16'h0);
        hold_done_r <= (hold_r == 16'h0);
        hold_cnt_r  <= hold_r;
      end else if (ref_hold_r) begin
        if (hold_cnt_r == 16'h1) begin
          ref_hold_r  <= 1'b0;
          hold_done_r <= 1'b1;
        end
        hold_cnt_r <= hold_cnt_r - 16'h1;
      end
    end
  end

  assign idx_now = decode_idx(ctrl_r[2:0], pin_r.a, pin_r.b,
                              pin_r.c, pin_r.rev);

  always_comb begin
    case (ctrl_r[2:0])
      REF_VOLT:   ref_mux = ref_volt_in;
      REF_CURR:   ref_mux = ref_curr_in;
      REF_FBUS:   ref_mux = ref_fbus_in;
      REF_KEYPAD: ref_mux = ref_keypad_in;
      REF_ACT, REF_ACTDIR, REF_BIN:
                  ref_mux = frq_r[idx_now];
      default:    ref_mux = frq_r[0];
    endcase
  end

  // frozen while holding; run inputs still act through run_enable_r
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_ref_r  <= 16'h0000;
      preset_idx_r <= 3'h0;
    end else if (!ref_hold_r) begin
      speed_ref_r  <= ref_mux;
      preset_idx_r <= idx_now;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  brake_lock_a: assert property (
    ts_r != TS_IDLE |=> !brake_ctrl_r)
    else $error("brake driven during tuning");
  tune_tmo_a: assert property (
    ts_r == TS_ARMED && tmo_r == 32'h1 && !start_rise &&
    !stop_cmd_in && !tune_wr |=> ts_r == TS_IDLE &&
    tune_sel_r == TUNE_NONE)
    else $error("tuning timeout not taken");
  stop_abort_a: assert property (
    stop_cmd_in && (ts_r == TS_ARMED || ts_r == TS_RUN)
    |=> ts_r == TS_IDLE && tune_sel_r == TUNE_NONE)
    else $error("stop did not abort tuning");
  fail_code_a: assert property (
    tune_fail |=> tune_sel_r == TUNE_FAIL && tuning_warn_r)
    else $error("failed tuning not reported");
  fault_keep_a: assert property (
    ts_r == TS_RUN && tuning_fault_in && !tuning_done_in &&
    !stop_cmd_in |=> ts_r == TS_RUN)
    else $error("tuning abandoned on fault");
  fresh_start_a: assert property (
    ts_r == TS_REARM && start |=> !run_enable_r [*2])
    else $error("held start accepted after tuning");
  stop_enter_a: assert property (
    stop_set |=> stop_lat_r ##1 !run_enable_r)
    else $error("stop state not entered");
  stop_hold_a: assert property (
    stop_lat_r && start |=> stop_lat_r)
    else $error("stop state left with run on");
  ref_frozen_a: assert property (
    ref_hold_r && $past(ref_hold_r) |-> $stable(speed_ref_r))
    else $error("reference moved during hold");
  tail_jerk_a: assert property (
    hold_done_r && ctrl_r[CTRL_JERK] |=> tail_jerk_r)
    else $error("hold-end jerks not applied");
  bin_idx_a: assert property (
    ctrl_r[2:0] == REF_BIN && !ref_hold_r
    |=> preset_idx_r == {$past(pin_r.c), $past(pin_r.b),
                         $past(pin_r.a)})
    else $error("binary index wrong");
  ramp_sw_a: assert property (
    dist2_r != 16'h0 |=> ramp_sw_r == $past(frq_r[0]))
    else $error("ramp switch not levelling freq");
  rescale_a: assert property (
    rc_start |=> rc_busy_r ##[1:9] (!rc_busy_r || rc_start))
    else $error("preset rescale stalled");

  tune_ok_c:  cover property (ts_r == TS_RUN ##1 ts_r == TS_REARM);
  tune_tmo_c: cover property (ts_r == TS_ARMED ##1 ts_r == TS_IDLE);
  stop_st_c:  cover property (stop_set ##1 stop_lat_r);
  hold_end_c: cover property (ref_hold_r ##1 hold_done_r);
endmodule

/* rtl/lift_ref_pkg.sv */
// Functional notes
// - I/O speed reference source picked by selector 0..6; default 0.
// - Activity coding: highest active select wins, none gives levelling.
// - Activity with direction: forward uses presets 0-3, reverse 4-7.
// - Binary coding: selects form index, input a is the LSB.
// - Jerk enable 0 disables rounding and jerks; 1 applies them.
// - Reference frozen for hold time after brake release and delays.
// - After hold expires, acc-decrease and dec-increase jerks apply.
// - Stop-state mode 1: all selects off forces stop state.
// - Leaving stop state needs both run inputs off first.
// - Tuning codes 0..3; code 5 reported after a failed attempt.
// - No start within 20 s after arming cancels, selector to 0.
// - Normal stop aborts tuning anytime, selector back to 0.
// - Brake control held inactive while tuning is in progress.
// - Faults during tuning do not abandon the run.
// - Warning raised when any requested tuning step failed.
// - After tuning a fresh rising start edge is needed.
// - Changed nonzero stop distance one recomputes deceleration one.
// - Nonzero stop distance two sets ramp switch to levelling freq.
// - Nominal linear speed change recomputes all frequency presets.
package lift_ref_pkg;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TUNE   = 8'h04;
  localparam logic [7:0] OFS_HOLD   = 8'h08;
  localparam logic [7:0] OFS_NOMLIN = 8'h0C;
  localparam logic [7:0] OFS_NOMFRQ = 8'h10;
  localparam logic [7:0] OFS_DIST1  = 8'h14;
  localparam logic [7:0] OFS_DIST2  = 8'h18;
  localparam logic [7:0] OFS_DECEL1 = 8'h1C;
  localparam logic [7:0] OFS_RAMPSW = 8'h20;
  localparam logic [7:0] OFS_STAT   = 8'h24;
  localparam logic [7:0] OFS_JERKDI = 8'h28;
  localparam logic [2:0] PAGE_LIN   = 3'h2;
  localparam logic [2:0] PAGE_FRQ   = 3'h3;
  localparam int CTRL_JERK  = 3;
  localparam int CTRL_STOPM = 4;
  localparam int STAT_WARN  = 0;
  localparam logic [2:0] REF_ACT    = 3'h0;
  localparam logic [2:0] REF_ACTDIR = 3'h1;
  localparam logic [2:0] REF_BIN    = 3'h2;
  localparam logic [2:0] REF_VOLT   = 3'h3;
  localparam logic [2:0] REF_CURR   = 3'h4;
  localparam logic [2:0] REF_FBUS   = 3'h5;
  localparam logic [2:0] REF_KEYPAD = 3'h6;
  localparam logic [2:0] TUNE_NONE  = 3'h0;
  localparam logic [2:0] TUNE_ENC   = 3'h3;
  localparam logic [2:0] TUNE_FAIL  = 3'h5;
  localparam logic [4:0]  RST_CTRL   = 5'h00;
  localparam logic [15:0] RST_HOLD   = 16'h0000;
  localparam logic [15:0] RST_NOMLIN = 16'h0100;
  localparam logic [15:0] RST_NOMFRQ = 16'h0032;
  localparam logic [15:0] RST_PRESET = 16'h0000;
  localparam int CLK_HZ      = 25_000_000;
  localparam int TUNE_WAIT_S = 20;
  localparam int TUNE_WAIT_CYC = TUNE_WAIT_S * CLK_HZ;
  typedef struct packed {
    logic fwd;
    logic rev;
    logic c;
    logic b;
    logic a;
  } pins_s;
  typedef enum logic [3:0] {
    TS_IDLE  = 4'b0001,
    TS_ARMED = 4'b0010,
    TS_RUN   = 4'b0100,
    TS_REARM = 4'b1000
  } tune_st_e;
endpackage

/* tb/lift_ctrl_model.sv */
module lift_ctrl_model
  import lift_ref_pkg::*;
(
  input  wire logic  pclk, // system clock
  input  wire pins_s want, // requested pin levels
  output pins_s      pins  // pins seen by the block
);
  timeunit 1ns;
  timeprecision 100ps;
  import lift_ref_pkg::*;
  // registers the requested pin levels onto pins, one clock later, unchanged
  always_ff @(posedge pclk) begin
    pins <= want;
  end
endmodule

/* tb/tb_lift_speed_ref_select.sv */
module tb_lift_speed_ref_select;
  import lift_ref_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata_r, rd;
  logic        pready_r, pslverr_r, err;
  pins_s       want = '0, pins;
  logic        stop_cmd_in = 0, brake_req_in = 0, release_in = 0;
  logic        tuning_done_in = 0, tuning_ok_in = 0, tuning_fault_in = 0;
  logic [15:0] refs [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
  logic [15:0] speed_ref_r;
  logic [2:0]  preset_idx_r;
  logic        run_enable_r, stop_state_r, ref_hold_r, round_en_r;
  logic        tail_jerk_r, brake_ctrl_r, tuning_run_r, tuning_warn_r;
  int          mismatches = 0, n_compared = 0, cyc = 0;
  always #20 pclk = ~pclk;
  lift_ctrl_model lift_ctrl_model_i (.pclk(pclk), .want(want), .pins(pins));
  lift_speed_ref_select #(.TUNE_TIMEOUT(50)) lift_speed_ref_select_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .pins(pins),
    .stop_cmd_in(stop_cmd_in), .brake_req_in(brake_req_in),
    .release_in(release_in), .tuning_done_in(tuning_done_in),
    .tuning_ok_in(tuning_ok_in), .tuning_fault_in(tuning_fault_in),
    .ref_volt_in(refs[0]), .ref_curr_in(refs[1]), .ref_fbus_in(refs[2]),
    .ref_keypad_in(refs[3]), .speed_ref_r(speed_ref_r),
    .preset_idx_r(preset_idx_r), .run_enable_r(run_enable_r),
    .stop_state_r(stop_state_r), .ref_hold_r(ref_hold_r),
    .round_en_r(round_en_r), .tail_jerk_r(tail_jerk_r),
    .brake_ctrl_r(brake_ctrl_r), .tuning_run_r(tuning_run_r),
    .tuning_warn_r(tuning_warn_r));
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask
  // held until pready is sampled high, then released
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready_r !== 1'b1);
    rd = prdata_r;
    err = pslverr_r;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // model edge, three sync stages, filter, output register, sample
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask
  function automatic logic [2:0] exp_idx(int m, logic [2:0] s, logic r);
    logic [2:0] e;
    if (m == 2) return s;
    e = s[2] ? 3'h3 : s[1] ? 3'h2 : s[0] ? 3'h1 : 3'h0;
    return (m == 1 && r) ? e + 3'h4 : e;
  endfunction
  task automatic t_regs;
    xfer(0, OFS_NOMLIN, 0); chk(rd, 32'h0100);
    xfer(0, OFS_NOMFRQ, 0); chk(rd, 32'h0032);
    xfer(0, OFS_CTRL, 0); chk(rd, 32'h0);
    xfer(1, 8'h3C, 32'h1); chk(err, 1'b1);
    $display("test regs done");
  endtask
  task automatic t_modes;
    for (int m = 3; m <= 6; m++) begin
      xfer(1, OFS_CTRL, m);
      settle();
      chk(speed_ref_r, refs[m-3]);
    end
    $display("test modes done");
  endtask
  task automatic t_coding;
    for (int m = 0; m <= 2; m++) begin
      xfer(1, OFS_CTRL, m);
      for (int v = 0; v < 16; v++) begin
        want <= {~v[3], v[3], v[2:0]};
        settle();
        chk(preset_idx_r, exp_idx(m, v[2:0], v[3]));
      end
    end
    $display("test coding done");
  endtask
  task automatic t_stop;
    want <= '0;
    xfer(1, OFS_CTRL, 32'h10);
    settle();
    want <= 5'b10000;
    settle();
    chk({stop_state_r, run_enable_r}, 2'b10);
    want <= 5'b10001;
    settle();
    chk({stop_state_r, run_enable_r}, 2'b10);
    want <= 5'b00001;
    settle();
    want <= 5'b10001;
    settle();
    chk({stop_state_r, run_enable_r}, 2'b01);
    want <= '0;
    xfer(1, OFS_CTRL, 0);
    $display("test stop done");
  endtask
  task automatic t_tune;
    settle();
    xfer(1, OFS_TUNE, 1);
    xfer(0, OFS_TUNE, 0); chk(rd, 32'h1);
    repeat (60) @(posedge pclk);
    xfer(0, OFS_TUNE, 0); chk(rd, 32'h0);
    xfer(1, OFS_TUNE, 2);
    brake_req_in <= 1;
    want <= 5'b10000;
    settle();
    chk({tuning_run_r, brake_ctrl_r}, 2'b10);
    stop_cmd_in <= 1;
    @(posedge pclk);
    stop_cmd_in <= 0;
    settle();
    chk(tuning_run_r, 1'b0);
    xfer(0, OFS_TUNE, 0); chk(rd, 32'h0);
    want <= '0;
    settle();
    xfer(1, OFS_TUNE, 3);
    want <= 5'b10000;
    settle();
    tuning_fault_in <= 1;
    @(posedge pclk);
    tuning_fault_in <= 0;
    tuning_ok_in <= 1;
    settle();
    chk(tuning_run_r, 1'b1);
    tuning_done_in <= 1;
    @(posedge pclk);
    tuning_done_in <= 0;
    settle();
    xfer(0, OFS_TUNE, 0); chk(rd, 32'h5);
    chk({tuning_warn_r, run_enable_r}, 2'b10);
    xfer(1, OFS_STAT, 1);
    chk(tuning_warn_r, 1'b0);
    want <= '0;
    settle();
    want <= 5'b10000;
    settle();
    chk(run_enable_r, 1'b1);
    $display("test tune done");
  endtask
  task automatic t_profile;
    xfer(1, 8'h44, 32'h80);
    settle();
    xfer(0, 8'h64, 0); chk(rd, 32'h19);
    xfer(1, OFS_NOMLIN, 32'h200);
    settle();
    xfer(0, 8'h64, 0); chk(rd, 32'hC);
    xfer(1, OFS_DIST1, 32'h100);
    xfer(0, OFS_DECEL1, 0); chk(rd, 32'h200);
    xfer(1, OFS_DECEL1, 32'h1234);
    xfer(1, OFS_DIST1, 32'h100);
    xfer(0, OFS_DECEL1, 0); chk(rd, 32'h1234);
    xfer(1, 8'h40, 32'h40);
    xfer(1, OFS_RAMPSW, 32'h55);
    settle();
    xfer(1, OFS_DIST2, 32'h1);
    xfer(0, OFS_RAMPSW, 0); chk(rd, 32'h6);
    chk(speed_ref_r, 16'h0006);
    xfer(1, OFS_HOLD, 32'hA);
    xfer(1, OFS_CTRL, 32'h8);
    settle();
    chk(round_en_r, 1'b1);
    release_in <= 1;
    want <= 5'b10001;
    settle();
    chk({ref_hold_r, tail_jerk_r, speed_ref_r}, {2'b10, 16'h0006});
    settle();
    chk({ref_hold_r, tail_jerk_r, speed_ref_r}, {2'b01, 16'h000C});
    xfer(1, OFS_CTRL, 32'h7);
    settle();
    chk({round_en_r, tail_jerk_r, speed_ref_r}, {2'b00, 16'h0006});
    release_in <= 0;
    want <= '0;
    $display("test profile done");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs();
    t_modes();
    t_coding();
    t_stop();
    t_tune();
    t_profile();
    final_report();
  end
endmodule
